// *** bprr_pkg.sv ***
// bprr_pkg: constants of the bit-recovery pll register bank
// assumes an 8-bit register port and a single 50 MHz system clock
package bprr_pkg;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_LOCK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BW_SEL    = 8'h01;
  localparam logic [7:0] ADDR_FREQ      = 8'h02;
  localparam logic [7:0] ADDR_EQU       = 8'h03;
  localparam logic [7:0] ADDR_AID       = 8'h04;
  localparam logic [7:0] ADDR_EYE       = 8'h0D;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0E;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0F;

  // field positions
  localparam int LOOP_BW_LSB  = 2;
  localparam int LP_BW_LSB    = 0;
  localparam int FREQ_LO_LSB  = 6;
  localparam int TAP1_LSB     = 3;
  localparam int TAP2_LSB     = 0;
  localparam int RUN3_BIT     = 7;
  localparam int NOM_LSB      = 0;
  localparam int LOCKF_LSB    = 0;
  localparam int ST_LONG_BIT  = 2;
  localparam int ST_INNER_BIT = 1;
  localparam int ST_LOCK_BIT  = 0;

  // reset values
  localparam logic [1:0] BW_RST    = 2'h0;
  localparam logic [9:0] FREQ_RST  = 10'h000;
  localparam logic [2:0] TAP_RST   = 3'h0;
  localparam logic [5:0] NOM_RST   = 6'h2E;
  localparam logic [3:0] LOCKF_RST = 4'h0;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  // codes and arithmetic offsets
  localparam logic [3:0]  LOCKF_HOLD      = 4'h8;
  localparam logic [1:0]  LP_BW_RESERVED  = 2'h3;
  localparam logic [2:0]  TAP_CODE_MAX    = 3'h5;
  localparam logic [10:0] FREQ_OFFSET     = 11'h010;
  localparam logic [6:0]  COUNT_OFFSET    = 7'h20;
  localparam logic [7:0]  JITTER_MIN_MEAS = 8'h11;

  // interrupt events
  localparam int IRQ_W        = 4;
  localparam int EV_LONG_RUN  = 0;
  localparam int EV_LOCK_UP   = 1;
  localparam int EV_LOCK_DOWN = 2;
  localparam int EV_BAD_CODE  = 3;

  // bandwidths in Hz
  localparam logic [15:0] HZ_42100 = 16'hA474;
  localparam logic [15:0] HZ_21000 = 16'h5208;
  localparam logic [15:0] HZ_10528 = 16'h2920;
  localparam logic [15:0] HZ_5264  = 16'h1490;
  localparam logic [15:0] HZ_2632  = 16'h0A48;

endpackage

// *** bprr_bw_decode.sv ***
// bprr_bw_decode: registered decode of bandwidth and tap codes
// assumes codes come from the register bank in the same clock domain
`timescale 1ns/100ps
module bprr_bw_decode (
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  input  wire logic [1:0]         loop_bw_code_i,
  input  wire logic [1:0]         lp_bw_code_i,
  input  wire logic [2:0]         tap_first_code_i,
  input  wire logic [2:0]         tap_second_code_i,
  output logic      [15:0]        loop_bw_hz_o,
  output logic      [15:0]        lowpass_bw_hz_o,
  output logic signed [4:0]       eq_coef_first_o,
  output logic signed [4:0]       eq_coef_second_o
);

  typedef struct packed {
    logic [15:0]        loop_hz;
    logic [15:0]        lp_hz;
    logic signed [4:0]  coef1;
    logic signed [4:0]  coef2;
  } bprr_dec_t;

  bprr_dec_t st_ff;
  bprr_dec_t nxt_st;

  // code to value tables
  always_comb begin
    nxt_st = st_ff;
    unique case (loop_bw_code_i)
      2'h0: nxt_st.loop_hz = bprr_pkg::HZ_21000;
      2'h1: nxt_st.loop_hz = bprr_pkg::HZ_10528;
      2'h2: nxt_st.loop_hz = bprr_pkg::HZ_5264;
      2'h3: nxt_st.loop_hz = bprr_pkg::HZ_2632;
    endcase
    unique case (lp_bw_code_i)
      2'h0: nxt_st.lp_hz = bprr_pkg::HZ_42100;
      2'h1: nxt_st.lp_hz = bprr_pkg::HZ_21000;
      2'h2: nxt_st.lp_hz = bprr_pkg::HZ_10528;
      2'h3: nxt_st.lp_hz = st_ff.lp_hz; // reserved, bank never holds it
    endcase
    // coefficient in units of -1/16
    nxt_st.coef1 = -$signed({2'h0, tap_first_code_i});
    nxt_st.coef2 = -$signed({2'h0, tap_second_code_i});
  end

  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '{loop_hz: bprr_pkg::HZ_21000, lp_hz: bprr_pkg::HZ_42100, coef1: 5'h00, coef2: 5'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign loop_bw_hz_o     = st_ff.loop_hz;
  assign lowpass_bw_hz_o  = st_ff.lp_hz;
  assign eq_coef_first_o  = st_ff.coef1;
  assign eq_coef_second_o = st_ff.coef2;

  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_loop_bw_slow: assert property (loop_bw_code_i == 2'h3 |=> loop_bw_hz_o == bprr_pkg::HZ_2632)
    else $error("loop bandwidth code 3 not decoded");
  a_loop_bw_fast: assert property (loop_bw_code_i == 2'h0 |=> loop_bw_hz_o == bprr_pkg::HZ_21000)
    else $error("loop bandwidth code 0 not decoded");
  a_lp_bw_wide: assert property (lp_bw_code_i == 2'h0 |=> lowpass_bw_hz_o == bprr_pkg::HZ_42100)
    else $error("lowpass bandwidth code 0 not decoded");
  a_tap_coef_step: assert property (tap_first_code_i == 3'h5 |=> eq_coef_first_o == -5'sd5)
    else $error("tap coefficient step wrong");

endmodule

// *** bprr_regs.sv ***
// bprr_regs: register bank of the bit-recovery pll
// assumes pll status inputs synchronous to clock_i and a one-cycle strobe port
`timescale 1ns/100ps
module bprr_regs (
  input  wire logic               clock_i,
  input  wire logic               arst_n_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [7:0]         reg_rdata_o,
  input  wire logic [7:0]         jitter_value_i,
  input  wire logic [7:0]         pll_asymmetry_i,
  input  wire logic               long_run_seen_i,
  input  wire logic               inner_range_flag_i,
  input  wire logic               pll_in_lock_i,
  input  wire logic [7:0]         eye_open_value_i,
  output logic                    irq_o,
  output logic      [1:0]         loop_bandwidth_sel_o,
  output logic      [1:0]         lowpass_bandwidth_sel_o,
  output logic      [15:0]        loop_bw_hz_o,
  output logic      [15:0]        lowpass_bw_hz_o,
  output logic      [9:0]         frequency_preset_code_o,
  output logic                    preset_update_o,
  output logic      [10:0]        preset_ratio_o,
  output logic      [2:0]         eq_tap_first_o,
  output logic      [2:0]         eq_tap_second_o,
  output logic signed [4:0]       eq_coef_first_o,
  output logic signed [4:0]       eq_coef_second_o,
  output logic                    run3_strategy_sel_o,
  output logic      [5:0]         transition_count_setting_o,
  output logic      [6:0]         target_ratio_o,
  output logic                    count_lock_en_o,
  output logic      [3:0]         lock_force_sel_o,
  output logic                    hold_mode_o,
  output logic                    jitter_measurable_o
);

  typedef struct packed {
    logic [1:0]                  loop_bw;
    logic [1:0]                  lp_bw;
    logic [9:0]                  freq_code;
    logic [1:0]                  freq_lo;
    logic                        update;
    logic [10:0]                 ratio;
    logic [2:0]                  tap1;
    logic [2:0]                  tap2;
    logic                        run3;
    logic [5:0]                  nom;
    logic [6:0]                  target;
    logic                        count_en;
    logic [3:0]                  lock_force;
    logic                        hold;
    logic                        jit_ok;
    logic                        lock_q;
    logic [bprr_pkg::IRQ_W-1:0]  irq_stat;
    logic [bprr_pkg::IRQ_W-1:0]  irq_mask;
    logic                        irq;
    logic [7:0]                  rdata;
  } bprr_main_t;

  bprr_main_t st_ff;
  bprr_main_t nxt_st;

  logic                        wr_bw;
  logic                        wr_freq;
  logic                        wr_equ;
  logic                        wr_aid;
  logic                        wr_lock;
  logic [1:0]                  lp_new;
  logic [2:0]                  tap1_new;
  logic [2:0]                  tap2_new;
  logic                        bad_code;
  logic [bprr_pkg::IRQ_W-1:0]  events;

  // write decode
  assign wr_bw    = reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_BW_SEL);
  assign wr_freq  = reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_FREQ);
  assign wr_equ   = reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_EQU);
  assign wr_aid   = reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_AID);
  assign wr_lock  = reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_LOCK_CTRL);
  assign lp_new   = reg_wdata_i[bprr_pkg::LP_BW_LSB +: 2];
  assign tap1_new = reg_wdata_i[bprr_pkg::TAP1_LSB +: 3];
  assign tap2_new = reg_wdata_i[bprr_pkg::TAP2_LSB +: 3];

  // reserved codes seen on a write
  assign bad_code = (wr_bw && (lp_new == bprr_pkg::LP_BW_RESERVED))
                 || (wr_equ && ((tap1_new > bprr_pkg::TAP_CODE_MAX) || (tap2_new > bprr_pkg::TAP_CODE_MAX)));

  // event sources for the sticky status
  always_comb begin
    events                          = '0;
    events[bprr_pkg::EV_LONG_RUN]   = long_run_seen_i;
    events[bprr_pkg::EV_LOCK_UP]    = pll_in_lock_i && !st_ff.lock_q;
    events[bprr_pkg::EV_LOCK_DOWN]  = !pll_in_lock_i && st_ff.lock_q;
    events[bprr_pkg::EV_BAD_CODE]   = bad_code;
  end

  // next-state logic
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.update = 1'b0;
    nxt_st.lock_q = pll_in_lock_i;

    // bandwidth select, reserved lowpass code leaves field as it was
    if (wr_bw) begin
      nxt_st.loop_bw = reg_wdata_i[bprr_pkg::LOOP_BW_LSB +: 2];
      if (lp_new != bprr_pkg::LP_BW_RESERVED) begin
        nxt_st.lp_bw = lp_new;
      end
    end

    // equalizer register stages the low two code bits
    if (wr_equ) begin
      nxt_st.freq_lo = reg_wdata_i[bprr_pkg::FREQ_LO_LSB +: 2];
      if (tap1_new <= bprr_pkg::TAP_CODE_MAX) begin
        nxt_st.tap1 = tap1_new;
      end
      if (tap2_new <= bprr_pkg::TAP_CODE_MAX) begin
        nxt_st.tap2 = tap2_new;
      end
    end

    // upper write applies the whole code at once
    if (wr_freq) begin
      nxt_st.freq_code = {reg_wdata_i, st_ff.freq_lo};
      nxt_st.update    = 1'b1;
    end
    nxt_st.ratio = {1'b0, nxt_st.freq_code} + bprr_pkg::FREQ_OFFSET;

    // outer-lock aid; bit 6 is dropped
    if (wr_aid) begin
      nxt_st.run3 = reg_wdata_i[bprr_pkg::RUN3_BIT];
      nxt_st.nom  = reg_wdata_i[bprr_pkg::NOM_LSB +: 6];
    end
    nxt_st.target   = {1'b0, nxt_st.nom} + bprr_pkg::COUNT_OFFSET;
    nxt_st.count_en = !nxt_st.run3;

    // lock force field and hold mode
    if (wr_lock) begin
      nxt_st.lock_force = reg_wdata_i[bprr_pkg::LOCKF_LSB +: 4];
    end
    nxt_st.hold = (nxt_st.lock_force == bprr_pkg::LOCKF_HOLD);

    nxt_st.jit_ok = (jitter_value_i >= bprr_pkg::JITTER_MIN_MEAS);

    // mask and sticky status, a new event wins over its clear
    if (reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_IRQ_MASK)) begin
      nxt_st.irq_mask = reg_wdata_i[bprr_pkg::IRQ_W-1:0];
    end
    if (reg_wr_i && (reg_addr_i == bprr_pkg::ADDR_IRQ_STAT)) begin
      nxt_st.irq_stat = (st_ff.irq_stat & ~reg_wdata_i[bprr_pkg::IRQ_W-1:0]) | events;
    end else begin
      nxt_st.irq_stat = st_ff.irq_stat | events;
    end
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);

    // read data, valid in the cycle after the strobe only
    nxt_st.rdata = bprr_pkg::BYTE_RST;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        bprr_pkg::ADDR_BW_SEL: nxt_st.rdata = pll_asymmetry_i;
        bprr_pkg::ADDR_FREQ:   nxt_st.rdata = jitter_value_i;
        bprr_pkg::ADDR_EQU: begin
          nxt_st.rdata[bprr_pkg::ST_LONG_BIT]  = long_run_seen_i;
          nxt_st.rdata[bprr_pkg::ST_INNER_BIT] = inner_range_flag_i;
          nxt_st.rdata[bprr_pkg::ST_LOCK_BIT]  = pll_in_lock_i;
        end
        bprr_pkg::ADDR_EYE:      nxt_st.rdata = eye_open_value_i;
        bprr_pkg::ADDR_IRQ_STAT: nxt_st.rdata = {{(8-bprr_pkg::IRQ_W){1'b0}}, st_ff.irq_stat};
        bprr_pkg::ADDR_IRQ_MASK: nxt_st.rdata = {{(8-bprr_pkg::IRQ_W){1'b0}}, st_ff.irq_mask};
        default:                 nxt_st.rdata = bprr_pkg::BYTE_RST;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '{loop_bw:    bprr_pkg::BW_RST,
                 lp_bw:      bprr_pkg::BW_RST,
                 freq_code:  bprr_pkg::FREQ_RST,
                 freq_lo:    2'h0,
                 update:     1'b0,
                 ratio:      bprr_pkg::FREQ_OFFSET,
                 tap1:       bprr_pkg::TAP_RST,
                 tap2:       bprr_pkg::TAP_RST,
                 run3:       1'b0,
                 nom:        bprr_pkg::NOM_RST,
                 target:     {1'b0, bprr_pkg::NOM_RST} + bprr_pkg::COUNT_OFFSET,
                 count_en:   1'b1,
                 lock_force: bprr_pkg::LOCKF_RST,
                 hold:       1'b0,
                 jit_ok:     1'b0,
                 lock_q:     1'b0,
                 irq_stat:   4'h0,
                 irq_mask:   4'h0,
                 irq:        1'b0,
                 rdata:      bprr_pkg::BYTE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // decoded bandwidths and tap coefficients
  bprr_bw_decode u_decode (
    .clock_i           (clock_i),
    .arst_n_i          (arst_n_i),
    .loop_bw_code_i    (st_ff.loop_bw),
    .lp_bw_code_i      (st_ff.lp_bw),
    .tap_first_code_i  (st_ff.tap1),
    .tap_second_code_i (st_ff.tap2),
    .loop_bw_hz_o      (loop_bw_hz_o),
    .lowpass_bw_hz_o   (lowpass_bw_hz_o),
    .eq_coef_first_o   (eq_coef_first_o),
    .eq_coef_second_o  (eq_coef_second_o)
  );

  // outputs straight from the state register
  assign reg_rdata_o                = st_ff.rdata;
  assign irq_o                      = st_ff.irq;
  assign loop_bandwidth_sel_o       = st_ff.loop_bw;
  assign lowpass_bandwidth_sel_o    = st_ff.lp_bw;
  assign frequency_preset_code_o    = st_ff.freq_code;
  assign preset_update_o            = st_ff.update;
  assign preset_ratio_o             = st_ff.ratio;
  assign eq_tap_first_o             = st_ff.tap1;
  assign eq_tap_second_o            = st_ff.tap2;
  assign run3_strategy_sel_o        = st_ff.run3;
  assign transition_count_setting_o = st_ff.nom;
  assign target_ratio_o             = st_ff.target;
  assign count_lock_en_o            = st_ff.count_en;
  assign lock_force_sel_o           = st_ff.lock_force;
  assign hold_mode_o                = st_ff.hold;
  assign jitter_measurable_o        = st_ff.jit_ok;

  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_freq_upper_load: assert property (wr_freq |=> frequency_preset_code_o[9:2] == $past(reg_wdata_i))
    else $error("upper preset bits not loaded");
  a_freq_low_pair: assert property (wr_equ ##1 wr_freq |=> frequency_preset_code_o[1:0] == $past(reg_wdata_i[7:6], 2))
    else $error("staged low bits not applied");
  a_freq_no_early: assert property (!wr_freq |=> $stable(frequency_preset_code_o) && !preset_update_o)
    else $error("preset changed without upper write");
  a_preset_ratio: assert property (preset_ratio_o == {1'b0, frequency_preset_code_o} + bprr_pkg::FREQ_OFFSET)
    else $error("preset ratio wrong");
  a_jitter_read: assert property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_FREQ |=> reg_rdata_o == $past(jitter_value_i))
    else $error("jitter read wrong");
  a_status_long: assert property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_EQU
                                  |=> reg_rdata_o[7:2] == {5'h00, $past(long_run_seen_i)})
    else $error("long run bit or reserved bits wrong");
  a_status_inner: assert property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_EQU |=> reg_rdata_o[1] == $past(inner_range_flag_i))
    else $error("inner lock bit wrong");
  a_status_lock: assert property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_EQU |=> reg_rdata_o[0] == $past(pll_in_lock_i))
    else $error("lock bit wrong");
  a_tap_write: assert property (wr_equ && tap1_new <= bprr_pkg::TAP_CODE_MAX |=> eq_tap_first_o == $past(tap1_new))
    else $error("eq_tap_first not written");
  a_lp_reserved_kept: assert property (wr_bw && lp_new == bprr_pkg::LP_BW_RESERVED |=> $stable(lowpass_bandwidth_sel_o))
    else $error("reserved lowpass code stored");
  a_strategy_sel: assert property (wr_aid |=> run3_strategy_sel_o == $past(reg_wdata_i[7]) && count_lock_en_o == !run3_strategy_sel_o)
    else $error("outer-lock strategy wrong");
  a_target_ratio: assert property (target_ratio_o == {1'b0, transition_count_setting_o} + bprr_pkg::COUNT_OFFSET)
    else $error("target ratio wrong");
  a_hold_entry: assert property (wr_lock && reg_wdata_i[3:0] == bprr_pkg::LOCKF_HOLD |=> hold_mode_o ##1 (hold_mode_o || $past(wr_lock)))
    else $error("hold mode not entered");
  a_eye_read: assert property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_EYE |=> reg_rdata_o == $past(eye_open_value_i))
    else $error("eye opening read wrong");
  a_bw_fields: assert property (wr_bw |=> loop_bandwidth_sel_o == $past(reg_wdata_i[3:2]))
    else $error("loop bandwidth field misplaced");

  c_preset_pair: cover property (wr_equ ##1 wr_freq ##1 preset_update_o);
  c_hold_mode: cover property ($rose(hold_mode_o));
  c_irq_raise: cover property ($rose(irq_o));
  c_lock_read: cover property (reg_rd_i && reg_addr_i == bprr_pkg::ADDR_EQU && pll_in_lock_i);

endmodule

// *** bprr_regs_tb_top.sv ***
// bprr_regs_tb_top: self-checking bench of the pll register bank
// assumes bprr_pkg and bprr_regs compiled first; the bench drives every port itself
`timescale 1ns/100ps
module bprr_regs_tb_top;
  logic              clock_i            = 1'b0;
  logic              arst_n_i           = 1'b0;
  logic [7:0]        reg_addr_i         = 8'h00;
  logic [7:0]        reg_wdata_i        = 8'h00;
  logic              reg_wr_i           = 1'b0;
  logic              reg_rd_i           = 1'b0;
  logic [7:0]        jitter_value_i     = 8'h00;
  logic [7:0]        pll_asymmetry_i    = 8'h00;
  logic              long_run_seen_i    = 1'b0;
  logic              inner_range_flag_i = 1'b0;
  logic              pll_in_lock_i      = 1'b0;
  logic [7:0]        eye_open_value_i   = 8'h00;
  logic [7:0]        reg_rdata_o;
  logic              irq_o;
  logic [1:0]        loop_bandwidth_sel_o;
  logic [1:0]        lowpass_bandwidth_sel_o;
  logic [15:0]       loop_bw_hz_o;
  logic [15:0]       lowpass_bw_hz_o;
  logic [9:0]        frequency_preset_code_o;
  logic              preset_update_o;
  logic [10:0]       preset_ratio_o;
  logic [2:0]        eq_tap_first_o;
  logic [2:0]        eq_tap_second_o;
  logic signed [4:0] eq_coef_first_o;
  logic signed [4:0] eq_coef_second_o;
  logic              run3_strategy_sel_o;
  logic [5:0]        transition_count_setting_o;
  logic [6:0]        target_ratio_o;
  logic              count_lock_en_o;
  logic [3:0]        lock_force_sel_o;
  logic              hold_mode_o;
  logic              jitter_measurable_o;
  int                miscompares = 0;
  int                n_tests     = 0;
  int                e;
  logic [15:0]       loop_hz [4] = '{bprr_pkg::HZ_21000, bprr_pkg::HZ_10528, bprr_pkg::HZ_5264, bprr_pkg::HZ_2632};
  logic [15:0]       lp_hz [3]   = '{bprr_pkg::HZ_42100, bprr_pkg::HZ_21000, bprr_pkg::HZ_10528};

  bprr_regs dut (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .jitter_value_i, .pll_asymmetry_i, .long_run_seen_i, .inner_range_flag_i, .pll_in_lock_i,
    .eye_open_value_i, .irq_o, .loop_bandwidth_sel_o, .lowpass_bandwidth_sel_o, .loop_bw_hz_o,
    .lowpass_bw_hz_o, .frequency_preset_code_o, .preset_update_o, .preset_ratio_o, .eq_tap_first_o,
    .eq_tap_second_o, .eq_coef_first_o, .eq_coef_second_o, .run3_strategy_sel_o,
    .transition_count_setting_o, .target_ratio_o, .count_lock_en_o, .lock_force_sel_o, .hold_mode_o,
    .jitter_measurable_o);

  // 50 MHz system clock
  always #10 clock_i = ~clock_i;

  // single exit point: counts, then verdict
  task automatic give_verdict();
    $display("TB: comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; returns just after the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask

  // one-cycle read strobe; data looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask

  // hang guard
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  initial begin
    // reset values while reset is held
    repeat (7) @(posedge clock_i);
    #1;
    chk(16'(transition_count_setting_o), 16'h002E);
    chk(16'(target_ratio_o), 16'h004E);
    chk(16'(preset_ratio_o), 16'h0010);
    chk(loop_bw_hz_o, bprr_pkg::HZ_21000);
    chk(16'({irq_o, hold_mode_o, count_lock_en_o}), 16'h0001);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    // every bandwidth code, lowpass 11 refused
    for (int i = 0; i < 4; i++) begin
      wr(bprr_pkg::ADDR_BW_SEL, {4'h0, 2'(i), 2'(i)});
      tick();
      chk(16'(loop_bandwidth_sel_o), 16'(i));
      chk(16'(lowpass_bandwidth_sel_o), (i < 3) ? 16'(i) : 16'h0002);
      chk(loop_bw_hz_o, loop_hz[i]);
      chk(lowpass_bw_hz_o, lp_hz[(i < 3) ? i : 2]);
    end
    rd(bprr_pkg::ADDR_IRQ_STAT, 8'h08);
    wr(bprr_pkg::ADDR_IRQ_STAT, 8'h08);
    rd(bprr_pkg::ADDR_IRQ_STAT, 8'h00);
    // back-to-back low bits then upper bits of the preset
    @(posedge clock_i);
    reg_addr_i  <= bprr_pkg::ADDR_EQU;
    reg_wdata_i <= 8'hC0;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_addr_i  <= bprr_pkg::ADDR_FREQ;
    reg_wdata_i <= 8'hFF;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
    #1;
    chk(16'(preset_update_o), 16'h0001);
    chk(16'(frequency_preset_code_o), 16'h03FF);
    chk(16'(preset_ratio_o), 16'h040F);
    tick();
    chk(16'(preset_update_o), 16'h0000);
    wr(bprr_pkg::ADDR_EQU, 8'h40);
    tick();
    chk(16'(frequency_preset_code_o), 16'h03FF);
    wr(bprr_pkg::ADDR_FREQ, 8'h00);
    chk(16'(frequency_preset_code_o), 16'h0001);
    chk(16'(preset_ratio_o), 16'h0011);
    // every tap code, 110 and 111 refused
    for (int t = 0; t < 8; t++) begin
      wr(bprr_pkg::ADDR_EQU, {2'b01, 3'(t), 3'(t)});
      tick();
      e = (t < 6) ? t : 5;
      chk(16'({eq_tap_first_o, eq_tap_second_o}), 16'({3'(e), 3'(e)}));
      chk({11'h000, eq_coef_first_o}, {11'h000, 5'(0 - e)});
      chk({11'h000, eq_coef_second_o}, {11'h000, 5'(0 - e)});
    end
    // outer-lock strategy and nominal setting; bit 6 ignored
    wr(bprr_pkg::ADDR_AID, 8'hC5);
    chk(16'({run3_strategy_sel_o, count_lock_en_o}), 16'h0002);
    chk(16'(target_ratio_o), 16'h0025);
    wr(bprr_pkg::ADDR_AID, 8'h6E);
    chk(16'({run3_strategy_sel_o, count_lock_en_o}), 16'h0001);
    chk(16'(transition_count_setting_o), 16'h002E);
    chk(16'(target_ratio_o), 16'h004E);
    rd(bprr_pkg::ADDR_AID, 8'h00);
    // hold mode from the lock-force field
    wr(bprr_pkg::ADDR_LOCK_CTRL, 8'h08);
    chk(16'({lock_force_sel_o, hold_mode_o}), 16'h0011);
    wr(bprr_pkg::ADDR_LOCK_CTRL, 8'h01);
    chk(16'({lock_force_sel_o, hold_mode_o}), 16'h0002);
    // readbacks of the pll status inputs
    @(posedge clock_i);
    jitter_value_i     <= 8'h11;
    pll_asymmetry_i    <= 8'hA5;
    eye_open_value_i   <= 8'h3C;
    long_run_seen_i    <= 1'b1;
    inner_range_flag_i <= 1'b1;
    pll_in_lock_i      <= 1'b1;
    rd(bprr_pkg::ADDR_FREQ, 8'h11);
    tick();
    chk({8'h00, reg_rdata_o}, 16'h0000);
    chk(16'(jitter_measurable_o), 16'h0001);
    rd(bprr_pkg::ADDR_EQU, 8'h07);
    rd(bprr_pkg::ADDR_EYE, 8'h3C);
    rd(bprr_pkg::ADDR_BW_SEL, 8'hA5);
    rd(8'h07, 8'h00);
    @(posedge clock_i);
    jitter_value_i     <= 8'h10;
    inner_range_flag_i <= 1'b0;
    long_run_seen_i    <= 1'b0;
    rd(bprr_pkg::ADDR_EQU, 8'h01);
    chk(16'(jitter_measurable_o), 16'h0000);
    // interrupt: sticky status, mask, clear
    rd(bprr_pkg::ADDR_IRQ_STAT, 8'h0B);
    wr(bprr_pkg::ADDR_IRQ_STAT, 8'hFF);
    rd(bprr_pkg::ADDR_IRQ_STAT, 8'h00);
    wr(bprr_pkg::ADDR_IRQ_MASK, 8'h06);
    rd(bprr_pkg::ADDR_IRQ_MASK, 8'h06);
    chk(16'(irq_o), 16'h0000);
    @(posedge clock_i);
    pll_in_lock_i <= 1'b0;
    tick();
    tick();
    chk(16'(irq_o), 16'h0001);
    rd(bprr_pkg::ADDR_IRQ_STAT, 8'h04);
    wr(bprr_pkg::ADDR_IRQ_STAT, 8'h04);
    tick();
    chk(16'(irq_o), 16'h0000);
    give_verdict();
  end
endmodule
